// *** rtl/serial_mode_control_one.sv ***
// Serial channel mode control: registers, transmit gating, direction and gap logic.
// Assumes a register master on clk and a free-running serial clock on link_clk.
//
// What this block does
// - A one-bit setting keeps the channel running or halts it while the system is idle.
// - In clocked I/O mode the duplex field picks none, receive, transmit or both, and the FIFO layout.
// - In UART mode the duplex field leaves line direction alone and only sets the FIFO layout.
// - Words are sent only while the transmit enable bit is set, in every transfer mode.
// - A three-bit gap code adds idle serial clock periods between words when buffering is on in clocked I/O mode with the serial clock output set.
// - The transmit FIFO setting is reinitialised when the channel is off or idles without run.
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "serial_mode_map.svh"

module serial_mode_control_one
    import serial_mode_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire logic                   link_clk,
    input  wire bus_req_t               bus_req,
    output logic [`SER_DATA_W-1:0]      rd_data,
    input  wire logic                   idle_mode,
    output logic                        txd,
    output logic                        tx_frame,
    output logic                        sclk_oe,
    output logic                        tx_dir_en,
    output logic                        rx_dir_en,
    output logic [1:0]                  fifo_arrangement,
    output logic [7:0]                  tx_fifo_config
);

    // ==========================================================
    // State of the register side
    typedef struct packed {
        logic                   channel_enable;
        mode_ctl_one_t          mode_ctl;
        chan_config_t           chan_cfg;
        logic [7:0]             fifo_cfg;
        logic [`SER_WORD_W-1:0] hold_data;
        logic [2:0]             hold_gap;
        logic                   hold_apply;
        logic                   pending;
        logic                   launched;
        logic                   req_tgl;
        logic                   ack_seen;
        logic [`SER_DATA_W-1:0] rd_data;
    } core_state_t;

    // ==========================================================
    // State of the link side
    typedef struct packed {
        link_phase_t              phase;
        logic [`SER_WORD_W-1:0]   shreg;
        logic [`SER_BITCNT_W-1:0] bitcnt;
        logic [`SER_GAPCNT_W-1:0] gapcnt;
        logic [2:0]               gap;
        logic                     apply;
        logic                     req_seen;
        logic                     ack_tgl;
        logic                     txd;
        logic                     frame;
    } link_state_t;

    core_state_t core;
    core_state_t next_core;
    link_state_t ls;
    link_state_t next_ls;

    logic ack_sync;
    logic req_sync;
    logic run;
    logic io_mode;
    logic tx_allowed;
    logic gap_apply;
    logic fifo_reinit;
    logic [`SER_DATA_W-1:0] rd_value;

    function automatic logic [`SER_GAPCNT_W-1:0] gap_len(input logic [2:0] code);
        gap_len = (code == `GAP_NONE) ? '0 : `GAP_ONE_PERIOD << (code - 3'h1);
    endfunction

    // ==========================================================
    // Crossings: toggles only, the held word is stable while launched
    level_sync3 #(.W(1)) u_ack_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    (ls.ack_tgl),
        .q    (ack_sync)
    );

    level_sync3 #(.W(1)) u_req_sync (
        .clk  (link_clk),
        .rstn (rstn),
        .d    (core.req_tgl),
        .q    (req_sync)
    );

    // ==========================================================
    // Mode decode
    always_comb begin
        run = core.channel_enable & ~(idle_mode & ~core.mode_ctl.idle_run_select);
        io_mode = (core.chan_cfg.transfer_mode == `MODE_IO);
        if (io_mode) begin
            tx_dir_en = run & core.mode_ctl.duplex_select[1];
            rx_dir_en = run & core.mode_ctl.duplex_select[0];
        end else begin
            tx_dir_en = run;
            rx_dir_en = run;
        end
        // Layout follows duplex in both modes whenever the FIFO is on
        fifo_arrangement = core.chan_cfg.fifo_enable ? core.mode_ctl.duplex_select
                                                     : `DUPLEX_NONE;
        tx_allowed = tx_dir_en & core.mode_ctl.transmit_enable_bit;
        gap_apply = io_mode & core.chan_cfg.sclk_output
                  & (core.chan_cfg.double_buffer | core.chan_cfg.fifo_enable);
        fifo_reinit = ~core.channel_enable | (idle_mode & ~core.mode_ctl.idle_run_select);
        sclk_oe = io_mode & core.chan_cfg.sclk_output & run;
    end

    always_comb begin
        rd_value = '0;
        case (bus_req.addr)
            `OFS_CHAN_ENABLE:  rd_value[0] = core.channel_enable;
            `OFS_MODE_CTL_ONE: rd_value[7:1] = core.mode_ctl[7:1];
            `OFS_CHAN_CONFIG:  rd_value[4:0] = core.chan_cfg;
            `OFS_STATUS:       rd_value[6:0] = {run, fifo_arrangement, rx_dir_en,
                                                tx_dir_en, tx_allowed, core.pending};
            `OFS_TX_FIFO_CFG:  rd_value[7:0] = core.fifo_cfg;
            default:           rd_value = '0;
        endcase
    end

    // ==========================================================
    // Register side
    always_comb begin
        next_core = core;
        next_core.rd_data = bus_req.rd ? rd_value : '0;
        if (bus_req.wr) begin
            case (bus_req.addr)
                `OFS_CHAN_ENABLE:  next_core.channel_enable = bus_req.wdata[0];
                `OFS_MODE_CTL_ONE: begin
                    next_core.mode_ctl          = bus_req.wdata[7:0];
                    next_core.mode_ctl.zero_bit = 1'b0;
                end
                `OFS_CHAN_CONFIG:  next_core.chan_cfg = bus_req.wdata[4:0];
                `OFS_TX_FIFO_CFG:  next_core.fifo_cfg = bus_req.wdata[7:0];
                `OFS_TX_DATA: begin
                    // A word written while one is waiting is dropped
                    if (!core.pending) begin
                        next_core.hold_data = bus_req.wdata[`SER_WORD_W-1:0];
                        next_core.pending   = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        if (fifo_reinit) begin
            next_core.fifo_cfg = `FIFO_CFG_RESET;
        end
        // Gap setting is frozen with the word so the link sees a stable copy
        if (core.pending && !core.launched && tx_allowed) begin
            next_core.launched   = 1'b1;
            next_core.req_tgl    = ~core.req_tgl;
            next_core.hold_gap   = core.mode_ctl.burst_gap_select;
            next_core.hold_apply = gap_apply;
        end
        if (ack_sync != core.ack_seen) begin
            next_core.ack_seen = ack_sync;
            next_core.pending  = 1'b0;
            next_core.launched = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            core <= '0;
        end else begin
            core <= next_core;
        end
    end

    assign rd_data        = core.rd_data;
    assign tx_fifo_config = core.fifo_cfg;

    // ==========================================================
    // Link side shifter, LSB first, gap counted in serial clock periods
    always_comb begin
        next_ls = ls;
        case (ls.phase)
            L_IDLE: begin
                if (req_sync != ls.req_seen) begin
                    next_ls.req_seen = req_sync;
                    next_ls.txd      = core.hold_data[0];
                    next_ls.shreg    = core.hold_data >> 1;
                    next_ls.gap      = core.hold_gap;
                    next_ls.apply    = core.hold_apply;
                    next_ls.bitcnt   = '0;
                    next_ls.frame    = 1'b1;
                    next_ls.phase    = L_SHIFT;
                end
            end
            L_SHIFT: begin
                if (ls.bitcnt == `LAST_BIT) begin
                    next_ls.frame = 1'b0;
                    next_ls.txd   = `IDLE_LINE;
                    if (ls.apply && ls.gap != `GAP_NONE) begin
                        next_ls.gapcnt = gap_len(ls.gap);
                        next_ls.phase  = L_GAP;
                    end else begin
                        next_ls.ack_tgl = ~ls.ack_tgl;
                        next_ls.phase   = L_IDLE;
                    end
                end else begin
                    next_ls.txd    = ls.shreg[0];
                    next_ls.shreg  = ls.shreg >> 1;
                    next_ls.bitcnt = ls.bitcnt + 1'b1;
                end
            end
            L_GAP: begin
                next_ls.gapcnt = ls.gapcnt - 1'b1;
                if (ls.gapcnt == `GAP_ONE_PERIOD) begin
                    next_ls.ack_tgl = ~ls.ack_tgl;
                    next_ls.phase   = L_IDLE;
                end
            end
            default: next_ls.phase = L_IDLE;
        endcase
    end

    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            ls       <= '0;
            ls.txd   <= `IDLE_LINE;
            ls.phase <= L_IDLE;
        end else begin
            ls <= next_ls;
        end
    end

    assign txd      = ls.txd;
    assign tx_frame = ls.frame;

    // ==========================================================
    // Checks
    a_idle_halts_tx: assert property (
        @(posedge clk) disable iff (!rstn)
        (idle_mode && !core.mode_ctl.idle_run_select) |-> !tx_allowed && !rx_dir_en)
        else $error("transfer allowed while halted in idle");

    a_io_duplex_dir: assert property (
        @(posedge clk) disable iff (!rstn)
        (io_mode && run) |-> (tx_dir_en == core.mode_ctl.duplex_select[1])
                          && (rx_dir_en == core.mode_ctl.duplex_select[0]))
        else $error("direction does not follow duplex field");

    a_uart_dir_free: assert property (
        @(posedge clk) disable iff (!rstn)
        (!io_mode && run) |-> tx_dir_en && rx_dir_en
                          && (!core.chan_cfg.fifo_enable
                              || fifo_arrangement == core.mode_ctl.duplex_select))
        else $error("duplex field steers lines in UART mode");

    a_launch_needs_enable: assert property (
        @(posedge clk) disable iff (!rstn)
        $changed(core.req_tgl) |-> $past(core.mode_ctl.transmit_enable_bit) && $past(run))
        else $error("word launched without transmit enable");

    a_held_word_waits: assert property (
        @(posedge clk) disable iff (!rstn)
        (core.pending && !core.launched && !tx_allowed) |=> !core.launched)
        else $error("held word left without permission");

    a_gap_length: assert property (
        @(posedge link_clk) disable iff (!rstn)
        (ls.phase == L_SHIFT && next_ls.phase == L_GAP) |=> ls.gapcnt == gap_len(ls.gap)
                                                            && !ls.frame)
        else $error("gap length does not match code");

    a_gap_line_idle: assert property (
        @(posedge link_clk) disable iff (!rstn)
        ls.phase == L_GAP |-> !ls.frame && ls.txd == `IDLE_LINE)
        else $error("line not idle during gap");

    a_gap_ignored: assert property (
        @(posedge link_clk) disable iff (!rstn)
        (ls.phase == L_SHIFT && ls.bitcnt == `LAST_BIT && !ls.apply) |=> ls.phase == L_IDLE)
        else $error("gap inserted outside clocked output mode");

    a_fifo_reinit: assert property (
        @(posedge clk) disable iff (!rstn)
        fifo_reinit |=> tx_fifo_config == `FIFO_CFG_RESET)
        else $error("transmit FIFO setting not reinitialised");

    a_frame_length: assert property (
        @(posedge link_clk) disable iff (!rstn)
        $rose(ls.frame) |-> ls.frame [*8] ##1 !ls.frame)
        else $error("frame is not eight periods long");

    c_gap_used:     cover property (@(posedge link_clk) disable iff (!rstn) ls.phase == L_GAP);
    c_word_sent:    cover property (@(posedge clk) disable iff (!rstn) $fell(core.pending));
    c_fifo_reinit:  cover property (@(posedge clk) disable iff (!rstn)
                                    fifo_reinit && core.fifo_cfg != `FIFO_CFG_RESET);
    c_uart_send:    cover property (@(posedge clk) disable iff (!rstn)
                                    !io_mode && $changed(core.req_tgl));

endmodule

// *** rtl/serial_mode_map.svh ***
// Register offsets, field values, reset values and counts of the serial mode block.
// Assumes a byte address bus of eight bits and a 32-bit data word.
`ifndef SERIAL_MODE_MAP_SVH
`define SERIAL_MODE_MAP_SVH

// ==========================================================
// Bus shape
`define SER_ADDR_W        8
`define SER_DATA_W        32
`define SER_WORD_W        8
`define SER_BITCNT_W      3
`define SER_GAPCNT_W      7

// ==========================================================
// Register offsets
`define OFS_CHAN_ENABLE   8'h00
`define OFS_MODE_CTL_ONE  8'h04
`define OFS_CHAN_CONFIG   8'h08
`define OFS_TX_DATA       8'h0C
`define OFS_STATUS        8'h10
`define OFS_TX_FIFO_CFG   8'h14

// ==========================================================
// Field values and reset values
`define MODE_IO           2'h0
`define DUPLEX_NONE       2'h0
`define GAP_NONE          3'h0
`define GAP_ONE_PERIOD    7'h01
`define LAST_BIT          3'h7
`define FIFO_CFG_RESET    8'h00
`define WORD_RESET        8'h00
`define IDLE_LINE         1'h1

`endif

// *** rtl/serial_mode_pkg.sv ***
// Types shared by the serial mode block: bus carrier, register layouts, states.
// Assumes the map header is on the include path.
`include "serial_mode_map.svh"

package serial_mode_pkg;

    // ==========================================================
    // Register bus carrier
    typedef struct packed {
        logic [`SER_ADDR_W-1:0] addr;
        logic [`SER_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } bus_req_t;

    // ==========================================================
    // Register layouts, low byte of the word
    typedef struct packed {
        logic       idle_run_select;
        logic [1:0] duplex_select;
        logic       transmit_enable_bit;
        logic [2:0] burst_gap_select;
        logic       zero_bit;
    } mode_ctl_one_t;

    typedef struct packed {
        logic       fifo_enable;
        logic       double_buffer;
        logic       sclk_output;
        logic [1:0] transfer_mode;
    } chan_config_t;

    // ==========================================================
    // Link side states
    typedef enum logic [1:0] {
        L_IDLE,
        L_SHIFT,
        L_GAP
    } link_phase_t;

endpackage

// *** rtl/level_sync3.sv ***
// Three-stage synchroniser; a change is taken once stages two and three agree.
// Assumes the input is a level or toggle from another clock domain.
`timescale 1ns/10ps

module level_sync3 #(
    parameter int W = 1
)(
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = d;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (st.s2 == st.s3) begin
            next_st.q = st.s3;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.q;

endmodule

// *** bench/serial_peer.sv ***
// Serial peer on the line: collects words sent LSB first and measures idle gaps.
// Assumes txd and tx_frame change on the rising edge of the free-running link clock.
`timescale 1ns/10ps

module serial_peer (
    input wire logic link_clk,
    input wire logic rstn,
    input wire logic txd,
    input wire logic tx_frame
);
    logic [7:0] shift;
    logic [7:0] rx_q[$];
    int         bit_n;
    int         idle_n;
    int         last_gap;
    int         bad_frames;

    // ==========================================================
    // Receive and gap measure
    always @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            bit_n = 0;
            idle_n = 0;
            last_gap = 0;
            bad_frames = 0;
        end else if (tx_frame === 1'b1) begin
            if (bit_n == 0) begin
                last_gap = idle_n;
            end
            shift = {txd, shift[7:1]};
            bit_n++;
            if (bit_n == 8) begin
                rx_q.push_back(shift);
                bit_n = 0;
            end
            idle_n = 0;
        end else begin
            // Short frames or a low idle line are counted, not hidden
            if (bit_n != 0 || txd !== 1'b1) begin
                bad_frames++;
            end
            bit_n = 0;
            idle_n++;
        end
    end
endmodule

// *** bench/serial_mode_control_one_test.sv ***
// Self-checking bench of the serial mode block with a serial peer on the line.
// Assumes the package, map header and peer model are compiled before it.
`timescale 1ns/10ps
`include "serial_mode_map.svh"

module serial_mode_control_one_test;
    import serial_mode_pkg::*;

    localparam int LIMIT = 60000;

    logic        clk;
    logic        rstn;
    logic        link_clk;
    bus_req_t    req;
    logic [31:0] rd_data;
    logic        idle_mode;
    logic        txd;
    logic        tx_frame;
    logic        sclk_oe;
    logic        tx_dir_en;
    logic        rx_dir_en;
    logic [1:0]  fifo_arrangement;
    logic [7:0]  tx_fifo_config;
    logic [31:0] v;
    logic [31:0] w;
    logic [7:0]  exp_q[$];
    int          fail_count;
    int          tests_run;
    int          cycles;
    int          codes[5] = '{0, 1, 3, 7, 7};
    int          base;
    int          gap;
    int          n;

    serial_mode_control_one DUT (
        .clk              (clk),
        .rstn             (rstn),
        .link_clk         (link_clk),
        .bus_req          (req),
        .rd_data          (rd_data),
        .idle_mode        (idle_mode),
        .txd              (txd),
        .tx_frame         (tx_frame),
        .sclk_oe          (sclk_oe),
        .tx_dir_en        (tx_dir_en),
        .rx_dir_en        (rx_dir_en),
        .fifo_arrangement (fifo_arrangement),
        .tx_fifo_config   (tx_fifo_config)
    );

    serial_peer peer (
        .link_clk (link_clk),
        .rstn     (rstn),
        .txd      (txd),
        .tx_frame (tx_frame)
    );

    // ==========================================================
    // Clocks and timeout
    always #4 clk = ~clk;

    initial begin
        link_clk = 1'b0;
        #3;
        forever #80 link_clk = ~link_clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            final_report();
        end
    end

    // ==========================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t %s: saw %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req.addr  <= a;
        req.wdata <= d;
        req.wr    <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        d = rd_data;
    endtask

    function automatic logic [31:0] mode_w(logic idle, logic [1:0] dup, logic go,
                                           logic [2:0] g);
        return {24'h0, idle, dup, go, g, 1'b0};
    endfunction

    // Mode fields first, enable last, never cleared mid-word
    task automatic setup(input logic [31:0] cfg, input logic [1:0] dup, input logic [2:0] g);
        wr(`OFS_MODE_CTL_ONE, mode_w(1'b0, dup, 1'b0, g));
        wr(`OFS_CHAN_CONFIG, cfg);
        wr(`OFS_MODE_CTL_ONE, mode_w(1'b0, dup, 1'b1, g));
    endtask

    task automatic send(input logic [7:0] b);
        wr(`OFS_TX_DATA, {24'h0, b});
        exp_q.push_back(b);
    endtask

    task automatic wait_done();
        int k;
        k = 0;
        v = 32'h1;
        while (v[0] !== 1'b0 && k < 3000) begin
            rd(`OFS_STATUS, v);
            k++;
        end
        check({31'h0, v[0]}, 32'h0, "word never finished");
    endtask

    task automatic check_rx();
        check(32'(peer.rx_q.size()), 32'(exp_q.size()), "word count");
        check(32'(peer.bad_frames), 32'h0, "frame shape");
        while (exp_q.size() > 0 && peer.rx_q.size() > 0) begin
            check({24'h0, peer.rx_q.pop_front()}, {24'h0, exp_q.pop_front()}, "word");
        end
        exp_q.delete();
        peer.rx_q.delete();
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence; no DMA here, so full duplex is free to use
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        idle_mode = 1'b0;
        req = '0;
        fail_count = 0;
        tests_run = 0;
        cycles = 0;
        void'($urandom(25));
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        rd(`OFS_MODE_CTL_ONE, v);
        check(v, 32'h0, "mode reset");
        rd(`OFS_TX_FIFO_CFG, v);
        check(v, 32'h0, "fifo cfg reset");
        check({31'h0, txd}, 32'h1, "idle line");
        w = $urandom & 32'hEE;
        wr(`OFS_MODE_CTL_ONE, w);
        rd(`OFS_MODE_CTL_ONE, v);
        check(v, w, "mode fields");
        rd(8'h3C, v);
        check(v, 32'h0, "unmapped");
        $display("test registers done");

        wr(`OFS_CHAN_ENABLE, 32'h1);
        for (int m = 0; m < 2; m++) begin
            wr(`OFS_CHAN_CONFIG, m ? 32'h11 : 32'h10);
            for (int d = 0; d < 4; d++) begin
                wr(`OFS_MODE_CTL_ONE, mode_w(1'b0, 2'(d), 1'b0, 3'h0));
                check({30'h0, fifo_arrangement}, 32'(d), "fifo layout");
                check({31'h0, tx_dir_en}, m ? 32'h1 : 32'(d >> 1), "tx dir");
                check({31'h0, rx_dir_en}, m ? 32'h1 : 32'(d & 1), "rx dir");
                rd(`OFS_STATUS, v);
                check(v, {25'h0, 1'b1, 2'(d), m ? 2'h3 : 2'(((d & 1) << 1) | (d >> 1)),
                          2'h0}, "status");
            end
        end
        $display("test duplex done");

        w = {24'h0, 8'($urandom) | 8'h01};
        wr(`OFS_TX_FIFO_CFG, w);
        wr(`OFS_MODE_CTL_ONE, mode_w(1'b1, 2'h3, 1'b0, 3'h0));
        @(posedge clk);
        idle_mode <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check({24'h0, tx_fifo_config}, w, "idle run keeps cfg");
        check({31'h0, tx_dir_en}, 32'h1, "idle run");
        wr(`OFS_MODE_CTL_ONE, mode_w(1'b0, 2'h3, 1'b0, 3'h0));
        @(posedge clk);
        #1;
        check({31'h0, tx_dir_en}, 32'h0, "idle halt");
        check({24'h0, tx_fifo_config}, 32'h0, "idle reinit");
        @(posedge clk);
        idle_mode <= 1'b0;
        wr(`OFS_TX_FIFO_CFG, w);
        wr(`OFS_CHAN_ENABLE, 32'h0);
        rd(`OFS_TX_FIFO_CFG, v);
        check(v, 32'h0, "off reinit");
        wr(`OFS_CHAN_ENABLE, 32'h1);
        $display("test idle done");

        wr(`OFS_CHAN_CONFIG, 32'h00);
        wr(`OFS_MODE_CTL_ONE, mode_w(1'b0, 2'h2, 1'b0, 3'h0));
        check({30'h0, fifo_arrangement}, 32'h0, "fifo off layout");
        send(8'($urandom));
        repeat (300) @(posedge clk);
        check(32'(peer.rx_q.size()), 32'h0, "sent while disabled");
        wr(`OFS_MODE_CTL_ONE, mode_w(1'b0, 2'h2, 1'b1, 3'h0));
        wait_done();
        check_rx();
        setup(32'h01, 2'h0, 3'h0);
        send(8'($urandom));
        wait_done();
        check_rx();
        $display("test transmit done");

        for (int i = 0; i < 5; i++) begin
            setup(i == 4 ? 32'h08 : 32'h0C, 2'h2, 3'(codes[i]));
            check({31'h0, sclk_oe}, i == 4 ? 32'h0 : 32'h1, "sclk drive");
            send(8'($urandom));
            wait_done();
            send(8'($urandom));
            wait_done();
            gap = peer.last_gap;
            if (i == 0) begin
                base = gap;
            end
            n = (i == 4 || codes[i] == 0) ? 0 : 1 << (codes[i] - 1);
            check(32'(gap >= base + n - 2 && gap <= base + n + 2), 32'h1, "gap");
            check_rx();
        end
        $display("test gap done");
        final_report();
    end
endmodule
